/* File: hdl/gp_port.sv */
// Eight-pin general-purpose I/O port with its two frame-addressed registers.
`timescale 1ns/1ps

module gp_port #(
   parameter int PIN_W = gp_pkg::GP_PIN_W
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic ctl_valid,
   input wire gp_pkg::gp_ctl_word_t ctl_word,
   output gp_pkg::gp_reply_word_t reply_word,
   output logic reply_valid,
   input wire logic [PIN_W-1:0] pin_in,
   output logic [PIN_W-1:0] pin_out,
   output logic [PIN_W-1:0] pin_oe
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [PIN_W-1:0] pin_level; // Pin levels after synchronising.
   logic [PIN_W-1:0] pin_orientation; // Direction register, one is input.
   logic [PIN_W-1:0] next_pin_orientation; // Next direction value.
   logic [PIN_W-1:0] next_pin_out; // Next data register value.
   logic [PIN_W-1:0] next_pin_oe; // Next output enables.
   gp_pkg::gp_reply_word_t next_reply_word; // Next reply word.
   logic next_reply_valid; // Next reply strobe.
   logic wr_data; // Frame writes the data register.
   logic wr_orient; // Frame writes the direction register.

   // True when a frame carries a write to the given register offset.
   function automatic logic write_hit(input gp_pkg::gp_ctl_word_t w,
                                      input logic [6:0] offs);
      write_hit = (w.read_not_write == gp_pkg::GP_RW_WRITE) &&
                  (w.reg_address == offs);
   endfunction

   // ------------------------------------------------------------------
   // Pin input synchroniser
   // ------------------------------------------------------------------
   // Pins are asynchronous to sys_clk, so levels pass two flops first.
   gp_sync #(
      .WIDTH(PIN_W)
   ) u_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in(pin_in),
      .sync_out(pin_level)
   );

   // ------------------------------------------------------------------
   // Register file next values
   // ------------------------------------------------------------------
   // The data register is kept apart from the pins, so a value written
   // while a pin is an input survives and is driven when it turns output.
   always_comb begin
      wr_data = ctl_valid && write_hit(ctl_word, gp_pkg::GP_PIN_DATA_OFFS);
      wr_orient = ctl_valid &&
                  write_hit(ctl_word, gp_pkg::GP_PIN_ORIENT_OFFS);
      next_pin_out = pin_out;
      next_pin_orientation = pin_orientation;
      if (wr_data) begin
         next_pin_out = ctl_word.data[PIN_W-1:0];
      end
      if (wr_orient) begin
         next_pin_orientation = ctl_word.data[PIN_W-1:0];
      end
      // Enables are held as flops of their own so outputs stay registered.
      next_pin_oe = ~next_pin_orientation;
   end

   // Reset leaves every pin an input, so nothing is driven until a direction write.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_out <= gp_pkg::GP_PIN_DATA_RST;
         pin_orientation <= gp_pkg::GP_PIN_ORIENT_RST;
         pin_oe <= '0;
      end else begin
         pin_out <= next_pin_out;
         pin_orientation <= next_pin_orientation;
         pin_oe <= next_pin_oe;
      end
   end

   // ------------------------------------------------------------------
   // Reply next values
   // ------------------------------------------------------------------
   // A write answers zeros; a read of the data address answers pin levels
   // rather than the stored byte; unimplemented addresses read as zero.
   always_comb begin
      next_reply_valid = ctl_valid;
      next_reply_word.upper = gp_pkg::GP_REPLY_UPPER;
      next_reply_word.data = gp_pkg::GP_UNMAPPED_READ;
      if (ctl_valid && ctl_word.read_not_write != gp_pkg::GP_RW_WRITE) begin
         if (ctl_word.reg_address == gp_pkg::GP_PIN_DATA_OFFS) begin
            next_reply_word.data = 8'(pin_level);
         end else if (ctl_word.reg_address ==
                      gp_pkg::GP_PIN_ORIENT_OFFS) begin
            next_reply_word.data = 8'(pin_orientation);
         end else begin
            next_reply_word.data = gp_pkg::GP_UNMAPPED_READ;
         end
      end
   end

   // The reply stands for one cycle after the frame is taken.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reply_word <= '0;
         reply_valid <= 1'b0;
      end else begin
         reply_word <= next_reply_word;
         reply_valid <= next_reply_valid;
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   // Helper flags: first cycle after reset, and whether direction was set.
   logic seen_cycle;
   logic orient_written;
   logic next_seen_cycle; // Next value of the first-cycle flag.
   logic next_orient_written; // Next value of the direction-written flag.

   // The written flag is sticky until reset; after a direction write the pins
   // may be quiet or driven, so the check covers only the time before it.
   always_comb begin
      next_seen_cycle = 1'b1;
      next_orient_written = orient_written | wr_orient;
   end

   // Both helper flags clear on reset so the checks restart with the port.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         seen_cycle <= 1'b0;
         orient_written <= 1'b0;
      end else begin
         seen_cycle <= next_seen_cycle;
         orient_written <= next_orient_written;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_data_write;
      wr_data && !wr_orient;
   endsequence

   sequence s_turn_output;
      wr_orient && !wr_data;
   endsequence

   property p_oe_per_bit;
      pin_oe == ~pin_orientation;
   endproperty
   a_oe_per_bit: assert property (p_oe_per_bit)
      else $error("output enable does not follow direction bits");

   property p_dir_write_oe;
      wr_orient |=> pin_oe == ~$past(ctl_word.data);
   endproperty
   a_dir_write_oe: assert property (p_dir_write_oe)
      else $error("direction write did not set enables");

   property p_drive_data;
      wr_data |=> ##[0:2] (pin_out == $past(ctl_word.data, 1) || wr_data);
   endproperty
   a_drive_data: assert property (p_drive_data)
      else $error("data register not driven on pins");

   property p_read_levels;
      (ctl_valid && ctl_word.read_not_write &&
       ctl_word.reg_address == gp_pkg::GP_PIN_DATA_OFFS)
      |=> reply_valid && reply_word.data == $past(pin_level);
   endproperty
   a_read_levels: assert property (p_read_levels)
      else $error("data read did not return pin levels");

   property p_quiet_until_config;
      !orient_written |-> pin_oe == '0;
   endproperty
   a_quiet_until_config: assert property (p_quiet_until_config)
      else $error("pin driven before direction was written");

   property p_reset_values;
      !seen_cycle |-> pin_out == gp_pkg::GP_PIN_DATA_RST &&
                      pin_orientation == gp_pkg::GP_PIN_ORIENT_RST;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("registers not all ones after reset");

   property p_write_reply_zero;
      (ctl_valid && ctl_word.read_not_write == gp_pkg::GP_RW_WRITE)
      |=> reply_valid && reply_word == '0;
   endproperty
   a_write_reply_zero: assert property (p_write_reply_zero)
      else $error("write reply was not all zeros");

   property p_retain_then_drive;
      s_data_write ##1 (!wr_data)[*1] ##0 s_turn_output
      |=> pin_out == $past(ctl_word.data, 2) &&
          pin_oe == ~$past(ctl_word.data, 1);
   endproperty
   a_retain_then_drive: assert property (p_retain_then_drive)
      else $error("retained data not driven after direction change");

endmodule

/* File: inc/gp_pkg.sv */
// Package with register map, reset values and carrier types of the I/O port.
package gp_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int GP_ADDR_W = 7; // Register address width of a frame.
   localparam int GP_PIN_W = 8; // Number of general-purpose pins.
   localparam logic [6:0] GP_PIN_DATA_OFFS = 7'h02; // pin_data_reg.
   localparam logic [6:0] GP_PIN_ORIENT_OFFS = 7'h03; // pin_orientation_reg.
   localparam logic [7:0] GP_PIN_DATA_RST = 8'hff; // All ones after reset.
   localparam logic [7:0] GP_PIN_ORIENT_RST = 8'hff; // All pins inputs.
   localparam logic [7:0] GP_UNMAPPED_READ = 8'h00; // Unimplemented reads.

   // ------------------------------------------------------------------
   // Control frame layout
   // ------------------------------------------------------------------
   localparam logic GP_RW_WRITE = 1'b0; // Flag value that asks a write.
   localparam logic [7:0] GP_REPLY_UPPER = 8'h00; // Upper reply byte.

   // Control word as received, most significant bit first.
   typedef struct packed {
      logic read_not_write; // One reads, zero writes.
      logic [6:0] reg_address; // reg_address_msb down to reg_address_lsb.
      logic [7:0] data; // Byte to write, ignored on reads.
   } gp_ctl_word_t;

   // Control word sent back in the cycle after the frame is taken.
   typedef struct packed {
      logic [7:0] upper; // Always zero.
      logic [7:0] data; // Read data, or zero after a write.
   } gp_reply_word_t;

endpackage

/* File: hdl/gp_sync.sv */
// Two flip-flop synchroniser for a bus of asynchronous pin levels.
`timescale 1ns/1ps

module gp_sync #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // First stage, read only by the second stage to keep metastability out.
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_sync_out;

   // ------------------------------------------------------------------
   // Next values
   // ------------------------------------------------------------------
   // Each stage simply samples the one before it.
   always_comb begin
      next_meta = async_in;
      next_sync_out = meta;
   end

   // Both stages clear to zero; the first real level appears two edges on.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= next_meta;
         sync_out <= next_sync_out;
      end
   end

endmodule

/* File: testbench/gp_pin_partner.sv */
// Model of the outside circuits that share the eight port pins.
`timescale 1ns/1ps

module gp_pin_partner (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] ext_drive,
   output logic [7:0] pin_level
);
   // ------------------------------------------------------------------
   // Wire resolution
   // ------------------------------------------------------------------
   // Outside circuits back off wherever the port drives.
   // This keeps every pin at a defined level, so no contention is modelled.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_level[i] = pin_oe[i] ? pin_out[i] : ext_drive[i];
      end
   end
endmodule

/* File: testbench/eight_bit_general_io_port_tb.sv */
// Self-checking bench for the general-purpose I/O port.
`timescale 1ns/1ps

module eight_bit_general_io_port_tb;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic sys_clk, reset_n, ctl_valid, reply_valid;
   gp_pkg::gp_ctl_word_t ctl_word; // Decoded control frame.
   gp_pkg::gp_reply_word_t reply_word; // Answer of the port.
   logic [7:0] pin_level, pin_out, pin_oe, ext_drive, dir_m, dat_m, rd;
   logic [15:0] lfsr; // Random source, fixed start value.
   int miscompares, checks_done;

   gp_port u_gp_port (.sys_clk(sys_clk), .reset_n(reset_n),
      .ctl_valid(ctl_valid), .ctl_word(ctl_word), .reply_word(reply_word),
      .reply_valid(reply_valid), .pin_in(pin_level), .pin_out(pin_out),
      .pin_oe(pin_oe));
   gp_pin_partner u_gp_pin_partner (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_drive(ext_drive), .pin_level(pin_level));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Clock of 50 ns period.
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Level a read of the data address should show.
   function automatic logic [7:0] exp_level(input logic [7:0] dir, dat, ext);
      return (dat & ~dir) | (ext & dir);
   endfunction

   task automatic check(input string name, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   // One frame; the answer is looked at in the cycle it stands.
   task automatic frame(input logic rnw, input logic [6:0] addr,
                        input logic [7:0] data, output logic [7:0] got);
      @(negedge sys_clk);
      ctl_valid = 1'b1;
      ctl_word = {rnw, addr, data};
      @(negedge sys_clk);
      ctl_valid = 1'b0;
      check("reply_valid", {15'h0000, reply_valid}, 16'h0001);
      check("reply_upper", {8'h00, reply_word.upper}, 16'h0000);
      got = reply_word.data;
      if (rnw == gp_pkg::GP_RW_WRITE) begin
         check("write_reply", {8'h00, got}, 16'h0000);
      end
   endtask

   // Lets pin levels pass the two-stage synchroniser.
   task automatic settle();
      repeat (3) @(negedge sys_clk);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the run needs.
   initial begin
      #(50 * 5000);
      miscompares++;
      tally_and_finish();
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      ctl_valid = 1'b0;
      ctl_word = 16'h0000;
      ext_drive = 8'h3c;
      lfsr = 16'h5fa0;
      miscompares = 0;
      checks_done = 0;
      repeat (2) @(negedge sys_clk);
      reset_n = 1'b1;
      check("rst_oe", {8'h00, pin_oe}, 16'h0000);
      check("rst_out", {8'h00, pin_out}, 16'h00ff);
      settle();
      frame(1'b1, gp_pkg::GP_PIN_ORIENT_OFFS, 8'h00, rd);
      check("rst_dir", {8'h00, rd}, 16'h00ff);
      frame(1'b1, gp_pkg::GP_PIN_DATA_OFFS, 8'h00, rd);
      check("rst_lvl", {8'h00, rd}, 16'h003c);
      $display("test reset done");
      // Data written while all pins are inputs is held, not driven.
      frame(1'b0, gp_pkg::GP_PIN_DATA_OFFS, 8'ha5, rd);
      check("held_oe", {8'h00, pin_oe}, 16'h0000);
      frame(1'b1, gp_pkg::GP_PIN_DATA_OFFS, 8'h00, rd);
      check("held_lvl", {8'h00, rd}, 16'h003c);
      frame(1'b0, gp_pkg::GP_PIN_ORIENT_OFFS, 8'h00, rd);
      check("held_out", {8'h00, pin_out}, 16'h00a5);
      check("all_oe", {8'h00, pin_oe}, 16'h00ff);
      $display("test retained data done");
      // Random directions, data and outside levels.
      for (int n = 0; n < 16; n++) begin
         lfsr = lfsr_next(lfsr);
         dir_m = lfsr[7:0];
         dat_m = lfsr[15:8];
         lfsr = lfsr_next(lfsr);
         ext_drive = lfsr[7:0];
         if (n == 0) dir_m = 8'h00;
         if (n == 1) dir_m = 8'hff;
         frame(1'b0, gp_pkg::GP_PIN_DATA_OFFS, dat_m, rd);
         frame(1'b0, gp_pkg::GP_PIN_ORIENT_OFFS, dir_m, rd);
         check("oe", {8'h00, pin_oe}, {8'h00, ~dir_m});
         check("out", {8'h00, pin_out}, {8'h00, dat_m});
         settle();
         frame(1'b1, gp_pkg::GP_PIN_DATA_OFFS, 8'h00, rd);
         check("lvl", {8'h00, rd},
               {8'h00, exp_level(dir_m, dat_m, ext_drive)});
         frame(1'b1, gp_pkg::GP_PIN_ORIENT_OFFS, 8'h00, rd);
         check("dir", {8'h00, rd}, {8'h00, dir_m});
      end
      $display("test random pins done");
      // Unmapped places take no write and read as zero.
      for (int i = 0; i < 8; i++) begin
         frame(1'b0, {3'(i), 4'h4}, 8'h5a, rd);
         frame(1'b1, {3'(i), 4'h4}, 8'h00, rd);
         check("unmapped", {8'h00, rd}, 16'h0000);
      end
      check("unm_out", {8'h00, pin_out}, {8'h00, dat_m});
      $display("test unmapped done");
      // Reset in mid-run acts without a clock edge.
      reset_n = 1'b0;
      #1;
      check("rr_oe", {8'h00, pin_oe}, 16'h0000);
      check("rr_out", {8'h00, pin_out}, 16'h00ff);
      @(negedge sys_clk);
      reset_n = 1'b1;
      frame(1'b1, gp_pkg::GP_PIN_ORIENT_OFFS, 8'h00, rd);
      check("rr_dir", {8'h00, rd}, 16'h00ff);
      $display("test second reset done");
      // Back-to-back frames: data held while input, driven next cycle.
      lfsr = lfsr_next(lfsr);
      @(negedge sys_clk);
      ctl_valid = 1'b1;
      ctl_word = {gp_pkg::GP_RW_WRITE, gp_pkg::GP_PIN_DATA_OFFS, lfsr[7:0]};
      @(negedge sys_clk);
      check("b2b_held_oe", {8'h00, pin_oe}, 16'h0000);
      ctl_word = {gp_pkg::GP_RW_WRITE, gp_pkg::GP_PIN_ORIENT_OFFS, 8'h00};
      @(negedge sys_clk);
      ctl_valid = 1'b0;
      check("b2b_valid", {15'h0000, reply_valid}, 16'h0001);
      check("b2b_out", {8'h00, pin_out}, {8'h00, lfsr[7:0]});
      check("b2b_oe", {8'h00, pin_oe}, 16'h00ff);
      $display("test back to back done");
      tally_and_finish();
   end
endmodule
